/* File: design/nti_consts.svh */
/*
  Constants of the oscillator tuner front end: register indices, field
  positions, reset values and widths.
  Assumes it is included by bare name from design files after the package.
*/
`ifndef NTI_CONSTS_SVH
`define NTI_CONSTS_SVH
`define NTI_IDX_HOLDOFF    8'h84
`define NTI_IDX_TUNE_LO    8'h85
`define NTI_IDX_TUNE_HI    8'h86
`define NTI_IDX_PHASE_OFS  8'h87
`define NTI_IDX_CONTROL    8'h88
`define NTI_IDX_QUAL_MODE  8'h89
`define NTI_IDX_STATUS     8'h8A
`define NTI_BIT_BYPASS     0
`define NTI_BIT_PDITHER    1
`define NTI_BIT_ADITHER    2
`define NTI_BIT_CLR_HOP    3
`define NTI_BIT_IMMEDIATE  4
`define NTI_BIT_PORT_B     6
`define NTI_POS_SYNC_SEL   7
`define NTI_POS_QMODE      0
`define NTI_POS_IMM_STAT   0
`define NTI_RST_16         16'h0000
`define NTI_RST_CTRL       9'h000
`define NTI_RST_LFSR       16'hACE1
`define NTI_MANT_W         14
`define NTI_EXP_W          3
`define NTI_OUT_W          16
`endif

/* File: design/nti_pkg.sv */
/*
  Types shared by the tuner front end.
  Assumes the constants header is included alongside.
*/
package nti_pkg;
  typedef enum logic [1:0] {
    NTI_BLANK_LOW   = 2'b00,
    NTI_CLOCK_HIGH  = 2'b01,
    NTI_RISE_EDGE   = 2'b10,
    NTI_FALL_EDGE   = 2'b11
  } nti_qmode_t;
  // Hold-off sequencer, Gray along idle -> count -> load
  typedef enum logic [1:0] {
    NTI_IDLE  = 2'b00,
    NTI_COUNT = 2'b01,
    NTI_LOAD  = 2'b11
  } nti_hop_t;
  typedef struct packed {
    logic [13:0] mantissa;
    logic [2:0]  exponent;
    logic        qualify;
  } nti_port_t;
  typedef struct packed {
    logic [15:0] i_data;
    logic [15:0] q_data;
    logic [2:0]  exponent;
    logic        valid;
  } nti_bb_t;
endpackage

/* File: design/nti_tuner.sv */
/*
  One channel of oscillator tuner front end: register file, shadowed tuning
  word with hold-off, phase accumulator with offset and dither, quadrature
  mixer, input port, sync pin and sample-qualify mode selection.
  Assumes all inputs synchronous to CLOCK_IN; the back end consumes BB_OUT.
*/
`include "nti_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module nti_tuner (
  input  wire logic              CLOCK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic              CE_IN,
  input  wire logic [7:0]        ADDR_IN,
  input  wire logic [15:0]       WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [15:0]       RDATA_OUT,
  input  wire nti_pkg::nti_port_t PORT_A_IN,
  input  wire nti_pkg::nti_port_t PORT_B_IN,
  input  wire logic [3:0]        SYNC_PINS_IN,
  input  wire logic              SLEEP_IN,
  output nti_pkg::nti_bb_t       BB_OUT,
  output logic                   ACTIVE_OUT
);
  // Register file
  logic [15:0] holdoff_reg, tune_lo_reg, tune_hi_reg, phase_ofs_reg;
  logic [8:0]  ctrl_reg;
  logic [1:0]  qmode_reg;
  logic [31:0] active_freq_reg, freq_next;
  logic [31:0] phase_acc_reg, phase_next;
  logic [15:0] count_reg, count_next;
  nti_pkg::nti_hop_t hop_reg, hop_next;
  logic        sync_d_reg, sleep_d_reg, qual_d_reg;
  logic [15:0] lfsr_reg;
  nti_pkg::nti_port_t samp_reg;
  logic        samp_valid_reg;

  // Sine lookup, quarter wave folded from an 8-bit phase
  function automatic logic signed [15:0] nti_sin(input logic [7:0] ph);
    logic [5:0]  idx;
    logic [15:0] mag;
    idx = ph[6] ? ~ph[5:0] : ph[5:0];
    mag = 16'(idx) * 16'h0324 + 16'h0000; // Linear quarter wave, 6 bit steps
    if (mag > 16'h7FFF) begin
      mag = 16'h7FFF;
    end
    return ph[7] ? -$signed(mag) : $signed(mag);
  endfunction

  // Multiply a sample by an oscillator value, keep 16 bits
  function automatic logic signed [15:0] nti_mix(input logic signed [13:0] a,
                                                 input logic signed [15:0] b);
    logic signed [29:0] p;
    p = a * b;
    return p[28:13];
  endfunction

  // Address decode and control fields
  wire sel_hold  = (ADDR_IN == `NTI_IDX_HOLDOFF);
  wire sel_lo    = (ADDR_IN == `NTI_IDX_TUNE_LO);
  wire sel_hi    = (ADDR_IN == `NTI_IDX_TUNE_HI);
  wire sel_ph    = (ADDR_IN == `NTI_IDX_PHASE_OFS);
  wire sel_ctl   = (ADDR_IN == `NTI_IDX_CONTROL);
  wire sel_qm    = (ADDR_IN == `NTI_IDX_QUAL_MODE);
  wire sel_st    = (ADDR_IN == `NTI_IDX_STATUS);
  wire bypass    = ctrl_reg[`NTI_BIT_BYPASS];
  wire pdither   = ctrl_reg[`NTI_BIT_PDITHER];
  wire adither   = ctrl_reg[`NTI_BIT_ADITHER];
  wire clr_hop   = ctrl_reg[`NTI_BIT_CLR_HOP];
  wire immediate = ctrl_reg[`NTI_BIT_IMMEDIATE];
  wire [1:0] sync_sel = ctrl_reg[`NTI_POS_SYNC_SEL +: 2];
  nti_pkg::nti_qmode_t qmode;
  assign qmode = nti_pkg::nti_qmode_t'(qmode_reg);

  // Port and sync pin selection
  nti_pkg::nti_port_t port_sel;
  assign port_sel = ctrl_reg[`NTI_BIT_PORT_B] ? PORT_B_IN : PORT_A_IN;
  wire sync_now  = SYNC_PINS_IN[sync_sel];
  wire sync_rise = sync_now & ~sync_d_reg;
  wire wake      = sleep_d_reg & ~SLEEP_IN;
  wire hop_event = sync_rise | wake;
  wire [31:0] shadow = {tune_hi_reg, tune_lo_reg};

  // Sample qualification per mode
  wire q     = port_sel.qualify;
  wire q_r   = q & ~qual_d_reg;
  wire q_f   = ~q & qual_d_reg;
  logic take, advance;
  always_comb begin
    unique case (qmode)
      nti_pkg::NTI_BLANK_LOW:  begin take = 1'b1; advance = 1'b1; end
      nti_pkg::NTI_CLOCK_HIGH: begin take = q;    advance = q;    end
      nti_pkg::NTI_RISE_EDGE:  begin take = q_r;  advance = q_r;  end
      nti_pkg::NTI_FALL_EDGE:  begin take = q_f;  advance = q_f;  end
    endcase
  end
  wire blank = (qmode == nti_pkg::NTI_BLANK_LOW) & ~q;

  // Hold-off sequencer and active word transfer
  wire transfer = (hop_reg == nti_pkg::NTI_LOAD) |
                  (hop_event & (immediate | (holdoff_reg == 16'h0000)));
  always_comb begin
    hop_next   = hop_reg;
    count_next = count_reg;
    freq_next  = active_freq_reg;
    unique case (hop_reg)
      nti_pkg::NTI_IDLE: begin
        if (hop_event & ~immediate & (holdoff_reg != 16'h0000)) begin
          hop_next   = nti_pkg::NTI_COUNT;
          count_next = holdoff_reg;
        end
      end
      nti_pkg::NTI_COUNT: begin
        count_next = count_reg - 16'h0001;
        if (count_reg == 16'h0001) begin
          hop_next = nti_pkg::NTI_LOAD;
        end
      end
      nti_pkg::NTI_LOAD: begin
        hop_next = nti_pkg::NTI_IDLE;
      end
      default: hop_next = nti_pkg::NTI_IDLE;
    endcase
    if (transfer) begin
      freq_next = shadow;
    end
  end

  // Phase accumulator, cleared on hop if asked, else advanced whenever the qualify mode takes a sample
  // Private to this channel, nothing shared with other instances
  always_comb begin
    phase_next = phase_acc_reg;
    if (transfer & clr_hop) begin
      phase_next = 32'h0000_0000;
    end else if (advance) begin
      phase_next = phase_acc_reg + active_freq_reg;
    end
  end

  // Oscillator output with offset and dither
  wire [15:0] ph_dith = pdither ? {8'h00, lfsr_reg[7:0]} : 16'h0000;
  wire [15:0] ph_full = phase_acc_reg[31:16] + phase_ofs_reg + ph_dith;
  wire [7:0]  ph_cos  = ph_full[15:8] + 8'h40;
  wire signed [15:0] a_dith = adither ? {{15{lfsr_reg[15]}}, lfsr_reg[9]} : 16'sh0000;
  wire signed [15:0] osc_sin = nti_sin(ph_full[15:8]) + a_dith;
  wire signed [15:0] osc_cos = nti_sin(ph_cos) + a_dith;

  // Mixer inputs: selected sample, zeroed when blanked
  wire signed [13:0] mant = blank ? 14'h0000 : $signed(port_sel.mantissa);
  wire signed [15:0] mix_i = nti_mix(mant, osc_cos);
  wire signed [15:0] mix_q = -nti_mix(mant, osc_sin);
  // Bypass samples are blanked like the mixer input
  wire signed [15:0] byp_i = blank ? 16'sh0000 : {PORT_A_IN.mantissa, 2'b00};
  wire signed [15:0] byp_q = blank ? 16'sh0000 : {PORT_B_IN.mantissa, 2'b00};
  nti_pkg::nti_bb_t bb_next;
  assign bb_next.i_data   = bypass ? byp_i : mix_i;
  assign bb_next.q_data   = bypass ? byp_q : mix_q;
  assign bb_next.exponent = port_sel.exponent;
  assign bb_next.valid    = take;

  // Read mux
  wire [15:0] rd_mux = sel_hold ? holdoff_reg :
                       sel_lo   ? tune_lo_reg :
                       sel_hi   ? tune_hi_reg :
                       sel_ph   ? phase_ofs_reg :
                       sel_ctl  ? {7'h00, ctrl_reg} :
                       sel_qm   ? {14'h0000, qmode_reg} :
                       sel_st   ? {14'h0000, hop_reg} : 16'h0000;

  // Registers written by software
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      holdoff_reg   <= `NTI_RST_16;
      tune_lo_reg   <= `NTI_RST_16;
      tune_hi_reg   <= `NTI_RST_16;
      phase_ofs_reg <= `NTI_RST_16;
      ctrl_reg      <= `NTI_RST_CTRL;
      qmode_reg     <= 2'b00;
      RDATA_OUT     <= 16'h0000;
    end else if (CE_IN) begin
      if (WR_IN & sel_hold) holdoff_reg   <= WDATA_IN;
      if (WR_IN & sel_lo)   tune_lo_reg   <= WDATA_IN;
      if (WR_IN & sel_hi)   tune_hi_reg   <= WDATA_IN;
      if (WR_IN & sel_ph)   phase_ofs_reg <= WDATA_IN;
      if (WR_IN & sel_ctl)  ctrl_reg      <= WDATA_IN[8:0];
      if (WR_IN & sel_qm)   qmode_reg     <= WDATA_IN[1:0];
      RDATA_OUT <= RD_IN ? rd_mux : 16'h0000;
    end
  end

  // Oscillator, sequencer and sample path state
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      active_freq_reg <= 32'h0000_0000;
      phase_acc_reg   <= 32'h0000_0000;
      count_reg       <= 16'h0000;
      hop_reg         <= nti_pkg::NTI_IDLE;
      sync_d_reg      <= 1'b0;
      sleep_d_reg     <= 1'b0;
      qual_d_reg      <= 1'b0;
      lfsr_reg        <= `NTI_RST_LFSR;
      BB_OUT          <= '0;
      ACTIVE_OUT      <= 1'b0;
    end else if (CE_IN) begin
      active_freq_reg <= freq_next;
      phase_acc_reg   <= phase_next;
      count_reg       <= count_next;
      hop_reg         <= hop_next;
      sync_d_reg      <= sync_now;
      sleep_d_reg     <= SLEEP_IN;
      qual_d_reg      <= q;
      lfsr_reg        <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
                          lfsr_reg[12] ^ lfsr_reg[10]};
      BB_OUT          <= bb_next;
      ACTIVE_OUT      <= ~SLEEP_IN;
    end
  end
endmodule
`default_nettype wire

/* File: bench/nti_tuner_asserts.sv */
/* Checker on the tuner register port, status index and sleep output.
   Assumes CE_IN stays high; bound into every nti_tuner instance. */
`timescale 1ns/1ps
`default_nettype none
module nti_tuner_asserts (
  input wire logic        CLOCK_IN,
  input wire logic        RST_N_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic        SLEEP_IN,
  input wire logic        ACTIVE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Write, then read of the same index on the next cycle
  sequence wr_rd_s(lo, hi);
    WR_IN && ADDR_IN inside {[lo:hi]} ##1 RD_IN && $stable(ADDR_IN);
  endsequence
  // Register port answers
  word_readback_a: assert property (wr_rd_s(8'h84, 8'h87) |=> RDATA_OUT == $past(WDATA_IN, 2))
    else $error("word readback wrong");
  ctrl_readback_a: assert property (wr_rd_s(8'h88, 8'h88) |=> RDATA_OUT == {7'h00, $past(WDATA_IN[8:0], 2)})
    else $error("control readback wrong");
  mode_readback_a: assert property (wr_rd_s(8'h89, 8'h89) |=> RDATA_OUT == {14'h0000, $past(WDATA_IN[1:0], 2)})
    else $error("mode readback wrong");
  unmapped_zero_a: assert property (RD_IN && !(ADDR_IN inside {[8'h84:8'h8A]}) |=> RDATA_OUT == 16'h0000)
    else $error("unmapped read not zero");
  idle_rdata_a: assert property (!RD_IN |=> RDATA_OUT == 16'h0000)
    else $error("read data without read");
  status_code_a: assert property (RD_IN && ADDR_IN == 8'h8A |=> RDATA_OUT[15:2] == 14'h0000 && RDATA_OUT[1:0] != 2'b10)
    else $error("bad hold-off state");
  // Active output is the inverted sleep input, one cycle later
  wake_follow_a: assert property (1'b1 |=> ACTIVE_OUT == !$past(SLEEP_IN))
    else $error("active flag lags");
  wake_steady_a: assert property ($stable(SLEEP_IN) [*2] |=> $stable(ACTIVE_OUT))
    else $error("active flag moved");
endmodule
bind nti_tuner nti_tuner_asserts chk_u (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .SLEEP_IN(SLEEP_IN), .ACTIVE_OUT(ACTIVE_OUT));
`default_nettype wire

/* File: bench/nti_adc_model.sv */
/* Converter model feeding both wideband ports.
   Assumes the bench sets sample, exponent and qualify pattern. */
`timescale 1ns/1ps
`default_nettype none
module nti_adc_model (
  input wire logic              clock_in,
  input wire logic              toggle_in,
  input wire logic              level_in,
  input wire logic [13:0]       mant_in,
  input wire logic [2:0]        exp_in,
  output var nti_pkg::nti_port_t port_a_out,
  output var nti_pkg::nti_port_t port_b_out
);
  initial port_a_out = '0;
  // Ports change just after each edge; B carries the inverted sample
  always @(posedge clock_in) begin
    port_a_out <= '{mant_in, exp_in, toggle_in ? ~port_a_out.qualify : level_in};
    port_b_out <= '{~mant_in, ~exp_in, toggle_in ? ~port_a_out.qualify : level_in};
  end
endmodule
`default_nettype wire

/* File: bench/nti_tuner_bench.sv */
/* Self-checking bench of the tuner: registers, hold-off, sync, data path.
   Assumes the checker is bound and CE_IN stays high. */
`timescale 1ns/1ps
`default_nettype none
module nti_tuner_bench;
  logic clock_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, sleep_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000, rdata_out;
  logic [3:0] sync_in = 4'h0;
  logic tog = 1'b0, lvl = 1'b1, active_out;
  logic [13:0] mant = 14'h0000;
  logic [2:0] expo = 3'h0;
  nti_pkg::nti_port_t pa, pb;
  nti_pkg::nti_bb_t bb;
  int err_count = 0, total_checks = 0, model[int];
  int ctl_bits[8] = '{0, 1, 2, 3, 4, 6, 7, 8};
  always #2.5 clock_in = ~clock_in;
  nti_adc_model adc_u (.clock_in(clock_in), .toggle_in(tog), .level_in(lvl), .mant_in(mant),
    .exp_in(expo), .port_a_out(pa), .port_b_out(pb));
  nti_tuner dut_u (.CLOCK_IN(clock_in), .RST_N_IN(rst_n_in), .CE_IN(1'b1), .ADDR_IN(addr_in),
    .WDATA_IN(wdata_in), .WR_IN(wr_in), .RD_IN(rd_in), .RDATA_OUT(rdata_out), .PORT_A_IN(pa),
    .PORT_B_IN(pb), .SYNC_PINS_IN(sync_in), .SLEEP_IN(sleep_in), .BB_OUT(bb),
    .ACTIVE_OUT(active_out));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Optional write, then read back against the model
  task automatic acc(input logic [7:0] a, input logic [15:0] d, input bit w);
    if (w) begin
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clock_in);
      if (model.exists(a)) model[a] = d & (a == 8'h88 ? 16'h01FF : a == 8'h89 ? 16'h0003 : 16'hFFFF);
    end
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    chk(rdata_out, model.exists(a) ? model[a][15:0] : 16'h0000, "read");
    @(posedge clock_in);
  endtask
  task automatic st(input int e);
    model[8'h8A] = e;
    acc(8'h8A, 16'h0000, 1'b0);
  endtask
  // Wait a bounded time for the baseband sample or exponent
  task automatic see(input bit k, input logic [15:0] e);
    int n;
    for (n = 0; n < 8; n++) begin
      @(posedge clock_in);
      if ((k ? {13'h0000, bb.exponent} : bb.i_data) === e) break;
    end
    chk({15'h0000, n < 8}, 16'h0001, "output");
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock_in);
    err_count++;
    summarize();
  end
  // Main sequence
  initial begin
    void'($urandom(84));
    for (int a = 8'h84; a <= 8'h89; a++) model[a] = 0;
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    for (int a = 8'h84; a <= 8'h8B; a++) acc(a[7:0], 16'h0000, 1'b0);
    repeat (12) acc(8'h84 + 8'($urandom_range(5)), 16'($urandom), 1'b1);
    acc(8'h90, 16'hFFFF, 1'b1);
    for (int m = 0; m < 4; m++) acc(8'h89, 16'(m), 1'b1);
    foreach (ctl_bits[b]) acc(8'h88, 16'h0001 << ctl_bits[b], 1'b1);
    acc(8'h84, 16'h0014, 1'b1);
    acc(8'h88, 16'h0000, 1'b1);
    sleep_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    st(1);
    repeat (30) @(posedge clock_in);
    st(0);
    for (int s = 0; s < 4; s++) begin
      acc(8'h88, 16'(s << 7) | 16'(s == 2) << 3, 1'b1);
      sync_in <= 4'h1 << ((s + 1) % 4);
      repeat (3) @(posedge clock_in);
      st(0);
      sync_in <= 4'h0;
      repeat (2) @(posedge clock_in);
      sync_in <= 4'h1 << s;
      repeat (3) @(posedge clock_in);
      st(1);
      sync_in <= 4'h0;
      repeat (30) @(posedge clock_in);
      st(0);
    end
    acc(8'h88, 16'h0010, 1'b1);
    sync_in <= 4'h1;
    repeat (3) @(posedge clock_in);
    st(0);
    sync_in <= 4'h0;
    mant <= 14'($urandom);
    expo <= 3'($urandom);
    acc(8'h89, 16'h0001, 1'b1);
    acc(8'h88, 16'h0001, 1'b1);
    see(1'b0, {mant, 2'b00});
    acc(8'h89, 16'h0000, 1'b1);
    lvl <= 1'b0;
    see(1'b0, 16'h0000);
    lvl <= 1'b1;
    acc(8'h89, 16'h0001, 1'b1);
    acc(8'h88, 16'h0040, 1'b1);
    see(1'b1, {13'h0000, ~expo});
    acc(8'h88, 16'h0000, 1'b1);
    see(1'b1, {13'h0000, expo});
    summarize();
  end
endmodule
`default_nettype wire
